// ### pwu_top.sv
// pin wake unit: eight-pin external interrupt with register port
// assumes pins synchronous to core_clk_i; core_clk_i keeps running in
// light stop, the clock gate bit only models the bus clock gate
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
module pwu_top
    import pwu_pkg::*;
(
    input  wire logic                core_clk_i,      // 200 MHz core clock
    input  wire logic                reset_i,         // sync reset, active high
    input  wire logic [ADDR_W-1:0]   addr_i,          // register word address
    input  wire logic [DATA_W-1:0]   wdata_i,         // write data
    input  wire logic                wr_i,            // write strobe
    input  wire logic                rd_i,            // read strobe
    output logic      [DATA_W-1:0]   rdata_o,         // read data, cycle after rd_i
    input  wire logic [NUM_PINS-1:0] irq_input_pin_i, // port_a_pins levels
    input  wire logic                wait_mode_i,     // chip in wait
    input  wire logic                light_stop_i,    // chip in light_stop
    input  wire logic                deep_stop_i,     // chip in deep_stop
    input  wire logic                debug_mode_i,    // background debug active
    output logic                     cpu_irq_o,       // interrupt request to cpu
    output logic                     wake_o,          // wake request to power control
    output logic      [NUM_PINS-1:0] pull_down_sel_o, // 1 pulldown, 0 pullup
    output logic                     evt_irq_o        // event status interrupt
);

    logic                detect_mode;
    logic                irq_enable;
    logic                irq_flag;
    logic [NUM_PINS-1:0] pin_enable;
    logic                clock_gate;
    logic [NUM_PINS-1:0] edge_hit;
    logic [NUM_PINS-1:0] level_hit;
    logic [EVT_W-1:0]    evt_status;
    logic [EVT_W-1:0]    evt_enable;
    logic [EVT_W-1:0]    evt_set;
    logic                unit_rst;
    logic                unit_live;
    logic                sc_wr;
    logic                ack_wr;
    logic                flag_set;
    logic                flag_clr;
    logic                next_flag;
    logic                next_irq;
    logic [DATA_W-1:0]   next_rdata;
    logic [NUM_PINS-1:0] pin_active;

    ////////////////////////////////////////////////////////////////////////////
    // deep stop drops the unit back to its reset state
    assign unit_rst  = reset_i | deep_stop_i;
    // light stop keeps sensing even with the bus clock gated off;
    // debug mode deliberately plays no part here
    assign unit_live = (clock_gate | light_stop_i) & ~deep_stop_i;

    assign sc_wr  = wr_i & clock_gate & (addr_i == OFS_STATUS_CONTROL);
    assign ack_wr = sc_wr & wdata_i[BIT_IRQ_ACK];

    ////////////////////////////////////////////////////////////////////////////
    // pin sensing
    pwu_pin_sense u_sense (
        .core_clk_i  (core_clk_i),
        .reset_i     (unit_rst),
        .pins_i      (irq_input_pin_i),
        .polarity_i  (pull_down_sel_o),
        .enable_i    (pin_enable),
        .edge_hit_o  (edge_hit),
        .level_hit_o (level_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // shared flag
    assign flag_set = unit_live & (|edge_hit | (detect_mode & |level_hit));
    // level mode refuses the acknowledge while any enabled pin is asserted
    assign flag_clr = ack_wr & (~detect_mode | ~|level_hit);
    assign next_flag = flag_set | (irq_flag & ~flag_clr);
    assign next_irq  = irq_flag & irq_enable;

    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            irq_flag <= RST_STATUS_CONTROL[BIT_IRQ_FLAG];
        end else begin
            irq_flag <= next_flag;
        end
    end

    // registered level, follows flag and enable one cycle later
    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            cpu_irq_o <= 1'b0;
        end else begin
            cpu_irq_o <= next_irq;
        end
    end

    // wake only matters while the chip sleeps
    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= next_irq & (wait_mode_i | light_stop_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            detect_mode <= RST_STATUS_CONTROL[BIT_DETECT_MODE];
            irq_enable  <= RST_STATUS_CONTROL[BIT_IRQ_ENABLE];
        end else if (sc_wr) begin
            detect_mode <= wdata_i[BIT_DETECT_MODE];
            irq_enable  <= wdata_i[BIT_IRQ_ENABLE];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            pin_enable <= RST_PIN_ENABLE;
        end else if (wr_i && clock_gate && addr_i == OFS_PIN_ENABLE) begin
            pin_enable <= wdata_i;
        end
    end

    // polarity doubles as the pull resistor select
    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            pull_down_sel_o <= RST_POLARITY;
        end else if (wr_i && clock_gate && addr_i == OFS_POLARITY) begin
            pull_down_sel_o <= wdata_i;
        end
    end

    // gate stays writable so software can turn the unit back on
    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            clock_gate <= RST_CLOCK_GATE;
        end else if (wr_i && addr_i == OFS_CLOCK_GATE) begin
            clock_gate <= wdata_i[BIT_CLOCK_GATE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event status block
    assign evt_set[EVT_DETECT]      = flag_set;
    assign evt_set[EVT_ACK_REFUSED] = ack_wr & ~flag_clr;

    pwu_event_status u_evt (
        .core_clk_i (core_clk_i),
        .reset_i    (unit_rst),
        .evt_set_i  (evt_set),
        .clr_wr_i   (wr_i & (addr_i == OFS_EVT_CLEAR)),
        .en_wr_i    (wr_i & (addr_i == OFS_EVT_ENABLE)),
        .wdata_i    (wdata_i[EVT_W-1:0]),
        .status_o   (evt_status),
        .enable_o   (evt_enable),
        .irq_o      (evt_irq_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read port: gated unit registers read zero, unmapped reads zero
    always_comb begin
        next_rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                OFS_STATUS_CONTROL: begin
                    if (clock_gate) begin
                        next_rdata[BIT_IRQ_FLAG]    = irq_flag;
                        next_rdata[BIT_IRQ_ENABLE]  = irq_enable;
                        next_rdata[BIT_DETECT_MODE] = detect_mode;
                    end
                end
                OFS_PIN_ENABLE: begin
                    if (clock_gate) begin
                        next_rdata = pin_enable;
                    end
                end
                OFS_POLARITY: begin
                    if (clock_gate) begin
                        next_rdata = pull_down_sel_o;
                    end
                end
                OFS_CLOCK_GATE: begin
                    next_rdata[BIT_CLOCK_GATE] = clock_gate;
                end
                OFS_EVT_STATUS: begin
                    next_rdata[EVT_W-1:0] = evt_status;
                end
                OFS_EVT_ENABLE: begin
                    next_rdata[EVT_W-1:0] = evt_enable;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    a_edge_sets_flag: assert property (
        (!deep_stop_i && unit_live && |edge_hit) |=> irq_flag)
        else $error("edge did not set flag");

    a_level_sets_flag: assert property (
        (!deep_stop_i && unit_live && detect_mode && |level_hit) |=> irq_flag)
        else $error("level did not set flag");

    a_flag_rise_cause: assert property (
        $rose(irq_flag) |-> $past(flag_set))
        else $error("flag rose without detection");

    a_pins_off_quiet: assert property (
        (!irq_flag && pin_enable == 8'h00) |=> !irq_flag)
        else $error("disabled pins set flag");

    a_irq_follows: assert property (
        (irq_flag && irq_enable && !deep_stop_i) |=> cpu_irq_o)
        else $error("request missing");

    a_irq_drops: assert property (
        (!irq_flag || !irq_enable) |=> !cpu_irq_o)
        else $error("request without flag and enable");

    a_ack_clears: assert property (
        (ack_wr && !detect_mode && !flag_set && !deep_stop_i) |=> !irq_flag ##1 !cpu_irq_o)
        else $error("acknowledge did not clear");

    a_ack_refused: assert property (
        (ack_wr && detect_mode && |level_hit && !deep_stop_i) |=> irq_flag)
        else $error("acknowledge cleared with pin asserted");

    a_ack_reads_zero: assert property (
        (rd_i && addr_i == OFS_STATUS_CONTROL) |=> !rdata_o[BIT_IRQ_ACK])
        else $error("acknowledge bit read as one");

    a_gate_stops: assert property (
        (!clock_gate && !light_stop_i && !irq_flag) |=> !irq_flag)
        else $error("gated unit set flag");

    a_deep_reset: assert property (
        deep_stop_i |=> (clock_gate && !irq_flag && pin_enable == 8'h00 && !irq_enable))
        else $error("deep stop left state");

    a_wake_wait: assert property (
        (wait_mode_i && irq_flag && irq_enable && !deep_stop_i) |=> wake_o)
        else $error("no wake from wait");

    // independent copy of the pin sense, so the checks do not reuse the sensor
    assign pin_active = ~(irq_input_pin_i ^ pull_down_sel_o);

    a_edge_shape: assert property (
        !$past(unit_rst) |-> edge_hit == (pin_enable & pin_active & ~$past(pin_active)))
        else $error("edge detect mismatch");

    a_level_shape: assert property (
        level_hit == (pin_enable & pin_active))
        else $error("level sense mismatch");

    a_flag_holds: assert property (
        (irq_flag && !ack_wr && !deep_stop_i) |=> irq_flag)
        else $error("flag cleared without acknowledge");

    a_write_no_flag: assert property (
        (sc_wr && wdata_i[BIT_IRQ_FLAG] && !flag_set && !irq_flag) |=> !irq_flag)
        else $error("write set the flag");

    a_flag_no_request: assert property (
        (!irq_enable && !sc_wr && unit_live && |edge_hit) |=> (irq_flag && !cpu_irq_o))
        else $error("masked flag missing or requested");

    a_enable_write: assert property (
        (wr_i && clock_gate && addr_i == OFS_PIN_ENABLE && !deep_stop_i)
        |=> pin_enable == $past(wdata_i))
        else $error("pin enable write lost");

    a_mode_write: assert property (
        (sc_wr && !deep_stop_i) |=> detect_mode == $past(wdata_i[BIT_DETECT_MODE]))
        else $error("detect mode write lost");

    a_pull_follows: assert property (
        (wr_i && clock_gate && addr_i == OFS_POLARITY && !deep_stop_i)
        |=> pull_down_sel_o == $past(wdata_i))
        else $error("pull select write lost");

    a_gate_no_write: assert property (
        (!clock_gate && wr_i && addr_i == OFS_PIN_ENABLE && !deep_stop_i)
        |=> $stable(pin_enable))
        else $error("gated unit took a write");

    a_wake_awake: assert property (
        (!wait_mode_i && !light_stop_i) |=> !wake_o)
        else $error("wake while running");

    a_light_senses: assert property (
        (light_stop_i && !deep_stop_i && |edge_hit) |=> irq_flag)
        else $error("light stop missed an edge");

    a_wake_light: assert property (
        (light_stop_i && irq_flag && irq_enable && !deep_stop_i) |=> wake_o)
        else $error("no wake from light stop");

    a_deep_outputs: assert property (
        deep_stop_i |=> (!cpu_irq_o && !wake_o && pull_down_sel_o == 8'h00))
        else $error("deep stop left outputs");

    a_debug_normal: assert property (
        (debug_mode_i && unit_live && |edge_hit) |=> irq_flag)
        else $error("debug mode blocked detection");

    c_edge_irq: cover property (!detect_mode && |edge_hit ##[1:3] cpu_irq_o);
    c_ack_refused: cover property (ack_wr && detect_mode && |level_hit);
    c_light_wake: cover property (light_stop_i && !clock_gate ##1 wake_o);
    c_evt_irq: cover property ($rose(evt_irq_o));
    c_wait_wake: cover property (wait_mode_i && irq_flag && irq_enable ##1 wake_o);

endmodule

// ### pwu_pkg.sv
// pin wake unit: shared constants, register map and field layout
// assumes an 8-bit register port with a 4-bit word address
package pwu_pkg;

    localparam int NUM_PINS = 8;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 8;
    localparam int EVT_W    = 2;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets (word index on the register port)
    localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PIN_ENABLE     = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_POLARITY       = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_CLOCK_GATE     = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS     = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR      = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE     = 4'h6;

    ////////////////////////////////////////////////////////////////////////////
    // key_irq_status_control fields
    localparam int BIT_DETECT_MODE = 0;
    localparam int BIT_IRQ_ENABLE  = 1;
    localparam int BIT_IRQ_ACK     = 2;
    localparam int BIT_IRQ_FLAG    = 3;
    // clock_gate_reg_two field
    localparam int BIT_CLOCK_GATE  = 0;
    // event status bits
    localparam int EVT_DETECT      = 0;
    localparam int EVT_ACK_REFUSED = 1;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [DATA_W-1:0]   RST_STATUS_CONTROL = 8'h00;
    localparam logic [NUM_PINS-1:0] RST_PIN_ENABLE     = 8'h00;
    localparam logic [NUM_PINS-1:0] RST_POLARITY       = 8'h00;
    localparam logic                RST_CLOCK_GATE     = 1'h1;
    localparam logic [EVT_W-1:0]    RST_EVT            = 2'h0;

endpackage

// ### pwu_pin_sense.sv
// pin wake unit: per-pin edge and level sensing
// assumes pins are already synchronous to core_clk_i
`timescale 1ns/1ps
module pwu_pin_sense
    import pwu_pkg::*;
(
    input  wire logic                core_clk_i,   // core clock
    input  wire logic                reset_i,      // sync reset, also deep stop
    input  wire logic [NUM_PINS-1:0] pins_i,       // irq_input_pin levels
    input  wire logic [NUM_PINS-1:0] polarity_i,   // pin_polarity bits
    input  wire logic [NUM_PINS-1:0] enable_i,     // pin_enable_bit bits
    output logic      [NUM_PINS-1:0] edge_hit_o,   // valid edge this cycle
    output logic      [NUM_PINS-1:0] level_hit_o   // enabled pin asserted
);

    logic [NUM_PINS-1:0] was_asserted;

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        logic asserted;
        // polarity 0: low is asserted, 1: high is asserted
        assign asserted = (pins_i[i] == polarity_i[i]);
        // starts as asserted so a pin already active is no edge
        always_ff @(posedge core_clk_i) begin
            if (reset_i) begin
                was_asserted[i] <= 1'b1;
            end else begin
                was_asserted[i] <= asserted;
            end
        end
        assign edge_hit_o[i]  = enable_i[i] & ~was_asserted[i] & asserted;
        assign level_hit_o[i] = enable_i[i] & asserted;
    end

endmodule

// ### pwu_event_status.sv
// pin wake unit: sticky event status, write-one clear, enable, level irq
// assumes one-cycle write strobes from the register decoder
`timescale 1ns/1ps
module pwu_event_status
    import pwu_pkg::*;
(
    input  wire logic             core_clk_i,   // core clock
    input  wire logic             reset_i,      // sync reset, also deep stop
    input  wire logic [EVT_W-1:0] evt_set_i,    // event pulses
    input  wire logic             clr_wr_i,     // write to clear register
    input  wire logic             en_wr_i,      // write to enable register
    input  wire logic [EVT_W-1:0] wdata_i,      // write data
    output logic      [EVT_W-1:0] status_o,     // sticky status
    output logic      [EVT_W-1:0] enable_o,     // enable register
    output logic                  irq_o         // level interrupt
);

    logic [EVT_W-1:0] next_status;
    logic [EVT_W-1:0] next_enable;

    // a set in the clearing cycle survives the clear
    assign next_status = (status_o & ~(clr_wr_i ? wdata_i : RST_EVT)) | evt_set_i;
    assign next_enable = en_wr_i ? wdata_i : enable_o;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            status_o <= RST_EVT;
            enable_o <= RST_EVT;
            irq_o    <= 1'b0;
        end else begin
            status_o <= next_status;
            enable_o <= next_enable;
            irq_o    <= |(next_status & next_enable);
        end
    end

endmodule

// ### pwu_key_model.sv
// pin wake unit bench: key switch model driving the eight interrupt pins
// assumes the pulls follow the unit's pull select outputs; one core clock
`timescale 1ns/1ps
module pwu_key_model
    import pwu_pkg::*;
(
    input  wire logic                core_clk_i, // core clock
    input  wire logic [NUM_PINS-1:0] press_i,    // 1 closes the switch
    input  wire logic [NUM_PINS-1:0] pull_dn_i,  // 1 pulldown, 0 pullup
    input  wire logic                lag_i,      // 1 adds a cycle of settling
    output logic      [NUM_PINS-1:0] pins_o      // pin levels
);
    logic [NUM_PINS-1:0] settle;
    // all eight pins alike, display function of shared pins is off
    // open switch rests at its pull, closed switch drives the opposite
    always_ff @(posedge core_clk_i) begin
        settle <= press_i ~^ pull_dn_i;
        pins_o <= lag_i ? settle : (press_i ~^ pull_dn_i);
    end
endmodule

// ### tb_top.sv
// pin wake unit testbench: register tasks, key model, checked sequences
// assumes pwu_top on one 200 MHz clock with synchronous reset
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top
    import pwu_pkg::*;
;
    logic                core_clk_i;
    logic                reset_i;
    logic [ADDR_W-1:0]   addr_i;
    logic [DATA_W-1:0]   wdata_i;
    logic                wr_i;
    logic                rd_i;
    logic [DATA_W-1:0]   rdata_o;
    logic [NUM_PINS-1:0] pins;
    logic [NUM_PINS-1:0] press_i;
    logic [NUM_PINS-1:0] pull_down_sel_o;
    logic                lag_i;
    logic                wait_mode_i;
    logic                light_stop_i;
    logic                deep_stop_i;
    logic                debug_mode_i;
    logic                cpu_irq_o;
    logic                wake_o;
    logic                evt_irq_o;
    int                  n_errors = 0;
    int                  n_tests = 0;

    pwu_top u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_input_pin_i(pins), .wait_mode_i(wait_mode_i), .light_stop_i(light_stop_i),
        .deep_stop_i(deep_stop_i), .debug_mode_i(debug_mode_i), .cpu_irq_o(cpu_irq_o),
        .wake_o(wake_o), .pull_down_sel_o(pull_down_sel_o), .evt_irq_o(evt_irq_o));
    pwu_key_model u_keys (.core_clk_i(core_clk_i), .press_i(press_i),
        .pull_dn_i(pull_down_sel_o), .lag_i(lag_i), .pins_o(pins));

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_i    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge core_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // covers model settling, edge sampling and the request register
    task automatic key(input logic [NUM_PINS-1:0] p);
        @(posedge core_clk_i);
        press_i <= p;
        idle(5);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_errors++;
        conclude();
    end

    initial begin
        {addr_i, wdata_i, wr_i, rd_i, press_i, lag_i} = '0;
        {wait_mode_i, light_stop_i, deep_stop_i, debug_mode_i} = '0;
        reset_i = 1'b1;
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rd(OFS_STATUS_CONTROL, 8'h00);
        rd(OFS_PIN_ENABLE, 8'h00);
        rd(OFS_CLOCK_GATE, 8'h01);
        rd(4'hF, 8'h00);
        wr(OFS_STATUS_CONTROL, 8'h0E);
        rd(OFS_STATUS_CONTROL, 8'h02);
        wr(OFS_STATUS_CONTROL, 8'h00);
        wr(OFS_POLARITY, 8'h5A);
        idle(2);
        `CHK(pull_down_sel_o, 8'h5A)
        for (int i = 0; i < NUM_PINS; i++) begin
            @(posedge core_clk_i);
            lag_i <= i[0];
            wr(OFS_PIN_ENABLE, 8'h01 << i);
            wr(OFS_STATUS_CONTROL, 8'h04);
            key(8'h01 << (i ^ 1));
            rd(OFS_STATUS_CONTROL, 8'h00);
            key(8'h01 << i);
            rd(OFS_STATUS_CONTROL, 8'h08);
            `CHK(cpu_irq_o, 1'b0)
            wr(OFS_STATUS_CONTROL, 8'h04);
            rd(OFS_STATUS_CONTROL, 8'h00);
            key(8'h00);
            rd(OFS_STATUS_CONTROL, 8'h00);
        end
        @(posedge core_clk_i);
        lag_i <= 1'b0;
        wr(OFS_STATUS_CONTROL, 8'h06);
        key(8'h80);
        `CHK(cpu_irq_o, 1'b1)
        rd(OFS_STATUS_CONTROL, 8'h0A);
        @(posedge core_clk_i);
        wait_mode_i <= 1'b1;
        idle(3);
        `CHK(wake_o, 1'b1)
        wr(OFS_STATUS_CONTROL, 8'h06);
        idle(3);
        `CHK(cpu_irq_o, 1'b0)
        `CHK(wake_o, 1'b0)
        @(posedge core_clk_i);
        wait_mode_i <= 1'b0;
        debug_mode_i <= 1'b1;
        wr(OFS_STATUS_CONTROL, 8'h04);
        rd(OFS_STATUS_CONTROL, 8'h00);
        wr(OFS_EVT_ENABLE, 8'h03);
        wr(OFS_STATUS_CONTROL, 8'h01);
        rd(OFS_STATUS_CONTROL, 8'h09);
        wr(OFS_STATUS_CONTROL, 8'h05);
        rd(OFS_STATUS_CONTROL, 8'h09);
        rd(OFS_EVT_STATUS, 8'h03);
        `CHK(evt_irq_o, 1'b1)
        wr(OFS_EVT_ENABLE, 8'h00);
        idle(2);
        `CHK(evt_irq_o, 1'b0)
        key(8'h00);
        wr(OFS_STATUS_CONTROL, 8'h05);
        rd(OFS_STATUS_CONTROL, 8'h01);
        wr(OFS_EVT_CLEAR, 8'h03);
        wr(OFS_EVT_ENABLE, 8'h03);
        rd(OFS_EVT_STATUS, 8'h00);
        `CHK(evt_irq_o, 1'b0)
        wr(OFS_STATUS_CONTROL, 8'h06);
        wr(OFS_CLOCK_GATE, 8'h00);
        rd(OFS_STATUS_CONTROL, 8'h00);
        wr(OFS_PIN_ENABLE, 8'hFF);
        key(8'h80);
        key(8'h00);
        wr(OFS_CLOCK_GATE, 8'h01);
        rd(OFS_PIN_ENABLE, 8'h80);
        rd(OFS_STATUS_CONTROL, 8'h02);
        wr(OFS_CLOCK_GATE, 8'h00);
        light_stop_i <= 1'b1;
        key(8'h80);
        `CHK(wake_o, 1'b1)
        @(posedge core_clk_i);
        light_stop_i <= 1'b0;
        wr(OFS_CLOCK_GATE, 8'h01);
        rd(OFS_STATUS_CONTROL, 8'h0A);
        @(posedge core_clk_i);
        deep_stop_i <= 1'b1;
        idle(2);
        @(posedge core_clk_i);
        deep_stop_i <= 1'b0;
        rd(OFS_PIN_ENABLE, 8'h00);
        rd(OFS_POLARITY, 8'h00);
        rd(OFS_STATUS_CONTROL, 8'h00);
        `CHK(cpu_irq_o, 1'b0)
        conclude();
    end
endmodule
